// *** rtl/cam_tap_pkg.sv ***
// Constants, types and encodings shared by the camera tap mapper files.
// How it works
// - 8-bit format puts pixel bits 0..7 on bits 0..7 of ports A..D.
// - 10-bit format: low bytes on A,C,E,D; top bits on B0/1,B4/5,F0/1,F4/5.
// - Tap and port usage follows the Base and Medium link configurations.
// - Serial answers leave on the SerTFG pair as 8N1 UART characters.
// - Serial commands arrive on the SerTC pair as 8N1 UART characters.
// - The power connector trigger input starts asynchronous exposures.
// - Camera control lines CC2, CC3 and CC4 are ignored.
// - Both triggers combine as active-low OR; exposure starts on its trailing edge.
package cam_tap_pkg;

  // Clock and timing.
  localparam int CLK_HZ = 250_000_000;
  localparam int UART_BAUD = 9600;
  localparam int UART_BIT_CYCLES = CLK_HZ / UART_BAUD;
  localparam int UART_DATA_BITS = 8;
  localparam int PIX_DIV = 6;

  // Pixel path geometry.
  localparam int TAPS = 4;
  localparam int PIX_W = 10;
  localparam int PORT_W = 8;
  localparam int NPORTS = 6;
  localparam int FIFO_DEPTH = 8;
  localparam int HI_BITS = 2;

  // Port indices, A through F.
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;

  // Ten-bit placement per tap: low byte port, top-bit port and top-bit offset.
  localparam int TEN_LOW_PORT [TAPS] = '{PORT_A, PORT_C, PORT_E, PORT_D};
  localparam int TEN_HI_PORT [TAPS] = '{PORT_B, PORT_B, PORT_F, PORT_F};
  localparam int TEN_HI_OFF [TAPS] = '{0, 4, 0, 4};

  // Synchroniser lanes and their idle levels.
  localparam int SYNC_PWR = 0;
  localparam int SYNC_LNK = 1;
  localparam int SYNC_RX = 2;
  localparam int NSYNC = 3;
  localparam logic [NSYNC-1:0] SYNC_IDLE = 3'h7;

  // Number of active taps.
  typedef enum logic [1:0] {
    TAPS_ONE = 2'h0,
    TAPS_TWO = 2'h1,
    TAPS_FOUR = 2'h2
  } tap_count_t;

  // UART states, Gray coded along idle, start, data, stop.
  typedef enum logic [1:0] {
    U_IDLE = 2'h0,
    U_START = 2'h1,
    U_DATA = 2'h3,
    U_STOP = 2'h2
  } uart_state_t;

endpackage

// *** rtl/stream_if.sv ***
// Valid/ready word stream between the mapper and its FIFO.
`timescale 1ns/1ps
interface stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic valid;
  logic ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// *** rtl/pixel_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input logic ref_clk,
  input logic arst_n,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic push;
  logic pop;

  // Honest full and empty straight from the fill count.
  assign in_s.ready = (q.cnt != FULL_CNT);
  assign out_s.valid = (q.cnt != '0);
  assign out_s.data = q.mem[q.rp];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Pointer and count update; simultaneous push and pop keep the count.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_s.data;
      d.wp = (q.wp == LAST_PTR) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LAST_PTR) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// *** rtl/camera_pixel_tap_mapper.sv ***
// Camera output mapper: pixel taps onto link ports, strobe, UART pair and trigger.
`timescale 1ns/1ps
module camera_pixel_tap_mapper #(
  parameter int UART_BIT_CYCLES_P = cam_tap_pkg::UART_BIT_CYCLES,
  parameter int PIX_DIV_P = cam_tap_pkg::PIX_DIV,
  parameter int FIFO_DEPTH_P = cam_tap_pkg::FIFO_DEPTH
) (
  input logic ref_clk,
  input logic arst_n,
  input logic [cam_tap_pkg::TAPS*cam_tap_pkg::PIX_W-1:0] pix_taps,
  input logic pix_line,
  input logic pix_frame,
  input logic pix_valid,
  output logic pix_ready,
  input logic ten_bit_mode,
  input cam_tap_pkg::tap_count_t tap_count,
  output logic [cam_tap_pkg::PORT_W-1:0] port_a,
  output logic [cam_tap_pkg::PORT_W-1:0] port_b,
  output logic [cam_tap_pkg::PORT_W-1:0] port_c,
  output logic [cam_tap_pkg::PORT_W-1:0] port_d,
  output logic [cam_tap_pkg::PORT_W-1:0] port_e,
  output logic [cam_tap_pkg::PORT_W-1:0] port_f,
  output logic line_valid_out,
  output logic frame_valid_out,
  output logic data_valid_out,
  output logic spare_out,
  output logic pixel_clk_out,
  input logic power_port_trigger_in,
  input logic link_port_trigger_in,
  input logic cc2_in,
  input logic cc3_in,
  input logic cc4_in,
  output logic exposure_start,
  input logic ser_tc_in,
  output logic ser_tfg_out,
  output logic [cam_tap_pkg::UART_DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err,
  input logic [cam_tap_pkg::UART_DATA_BITS-1:0] tx_data,
  input logic tx_valid,
  output logic tx_ready
);
  import cam_tap_pkg::*;

  localparam int CW = $clog2(UART_BIT_CYCLES_P + 1);
  localparam int DW = $clog2(PIX_DIV_P + 1);
  localparam int WORD_W = TAPS * PIX_W + 2;
  localparam logic [CW-1:0] BIT_LAST = CW'(UART_BIT_CYCLES_P - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(UART_BIT_CYCLES_P / 2 - 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(PIX_DIV_P - 1);
  localparam logic [DW-1:0] DIV_RISE = DW'(PIX_DIV_P / 2 - 1);
  localparam logic [2:0] DATA_LAST = 3'(UART_DATA_BITS - 1);

  typedef logic [NPORTS-1:0][PORT_W-1:0] ports_t;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic trig_act;
    logic exp_start;
    logic [DW-1:0] pdiv;
    logic pclk;
    ports_t ports;
    logic lval;
    logic fval;
    uart_state_t rx_st;
    logic [CW-1:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [UART_DATA_BITS-1:0] rx_sh;
    logic [UART_DATA_BITS-1:0] rx_data;
    logic rx_valid;
    logic rx_ferr;
    uart_state_t tx_st;
    logic [CW-1:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [UART_DATA_BITS-1:0] tx_sh;
    logic tx_line;
  } state_t;

  state_t q;
  state_t d;
  logic pix_en;
  logic trig_comb;
  logic rx_pin;
  logic [TAPS*PIX_W-1:0] word_taps;
  logic word_line;
  logic word_frame;

  stream_if #(.W(WORD_W)) fifo_in ();
  stream_if #(.W(WORD_W)) fifo_out ();

  // Places each active tap on its link ports; everything else stays low.
  function automatic ports_t map_ports(
    input logic [TAPS*PIX_W-1:0] taps,
    input logic ten,
    input tap_count_t ntap
  );
    ports_t p;
    logic [PIX_W-1:0] px;
    int active;
    p = '0;
    px = '0;
    case (ntap)
      TAPS_TWO: active = 2;
      TAPS_FOUR: active = TAPS;
      default: active = 1;
    endcase
    for (int k = 0; k < TAPS; k++) begin
      px = taps[k*PIX_W +: PIX_W];
      if (k < active) begin
        if (ten) begin
          p[TEN_LOW_PORT[k]] = px[PORT_W-1:0];
          p[TEN_HI_PORT[k]][TEN_HI_OFF[k] +: HI_BITS] = px[PIX_W-1:PORT_W];
        end else begin
          p[k] = px[PORT_W-1:0];
        end
      end
    end
    return p;
  endfunction

  // Pixel words with their line and frame flags pass through the FIFO.
  assign fifo_in.data = {pix_frame, pix_line, pix_taps};
  assign fifo_in.valid = pix_valid;
  assign pix_ready = fifo_in.ready;
  assign fifo_out.ready = pix_en;
  assign word_taps = fifo_out.data[TAPS*PIX_W-1:0];
  assign word_line = fifo_out.data[TAPS*PIX_W];
  assign word_frame = fifo_out.data[TAPS*PIX_W+1];

  pixel_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_s(fifo_in),
    .out_s(fifo_out)
  );

  // Strobe divider wrap launches a new pixel on the falling strobe edge.
  assign pix_en = (q.pdiv == DIV_LAST);

  // Either trigger pin low holds the combined trigger active.
  assign trig_comb = ~q.sync2[SYNC_PWR] | ~q.sync2[SYNC_LNK];
  assign rx_pin = q.sync2[SYNC_RX];

  // Next-state logic for the pixel, trigger and UART parts.
  always_comb begin
    d = q;
    d.rx_valid = 1'b0;
    d.rx_ferr = 1'b0;

    // Pins pass two flip-flops; the reserved control lines are never sampled.
    d.sync1 = {ser_tc_in, link_port_trigger_in, power_port_trigger_in};
    d.sync2 = q.sync1;

    // Exposure start pulses when the combined trigger is released.
    d.trig_act = trig_comb;
    d.exp_start = q.trig_act & ~trig_comb;

    // Strobe low for the first half of the pixel period, high for the rest.
    if (pix_en) begin
      d.pdiv = '0;
      d.pclk = 1'b0;
      if (fifo_out.valid) begin
        d.ports = map_ports(word_taps, ten_bit_mode, tap_count);
        d.lval = word_line;
        d.fval = word_frame;
      end else begin
        d.ports = '0;
        d.lval = 1'b0;
      end
    end else begin
      d.pdiv = q.pdiv + 1'b1;
      if (q.pdiv == DIV_RISE) begin
        d.pclk = 1'b1;
      end
    end

    // Receiver: start bit checked mid-bit, then data LSB first, then stop.
    case (q.rx_st)
      U_IDLE: begin
        d.rx_cnt = '0;
        if (!rx_pin) begin
          d.rx_st = U_START;
        end
      end
      U_START: begin
        if (q.rx_cnt == HALF_LAST) begin
          d.rx_cnt = '0;
          d.rx_bit = '0;
          d.rx_st = rx_pin ? U_IDLE : U_DATA;
        end else begin
          d.rx_cnt = q.rx_cnt + 1'b1;
        end
      end
      U_DATA: begin
        if (q.rx_cnt == BIT_LAST) begin
          d.rx_cnt = '0;
          d.rx_sh = {rx_pin, q.rx_sh[UART_DATA_BITS-1:1]};
          if (q.rx_bit == DATA_LAST) begin
            d.rx_st = U_STOP;
          end else begin
            d.rx_bit = q.rx_bit + 1'b1;
          end
        end else begin
          d.rx_cnt = q.rx_cnt + 1'b1;
        end
      end
      U_STOP: begin
        if (q.rx_cnt == BIT_LAST) begin
          d.rx_cnt = '0;
          d.rx_st = U_IDLE;
          if (rx_pin) begin
            d.rx_data = q.rx_sh;
            d.rx_valid = 1'b1;
          end else begin
            d.rx_ferr = 1'b1;
          end
        end else begin
          d.rx_cnt = q.rx_cnt + 1'b1;
        end
      end
      default: begin
        d.rx_st = U_IDLE;
      end
    endcase

    // Transmitter: start bit, eight data bits LSB first, one stop bit.
    case (q.tx_st)
      U_IDLE: begin
        d.tx_line = 1'b1;
        d.tx_cnt = '0;
        if (tx_valid) begin
          d.tx_sh = tx_data;
          d.tx_line = 1'b0;
          d.tx_st = U_START;
        end
      end
      U_START: begin
        if (q.tx_cnt == BIT_LAST) begin
          d.tx_cnt = '0;
          d.tx_bit = '0;
          d.tx_line = q.tx_sh[0];
          d.tx_st = U_DATA;
        end else begin
          d.tx_cnt = q.tx_cnt + 1'b1;
        end
      end
      U_DATA: begin
        if (q.tx_cnt == BIT_LAST) begin
          d.tx_cnt = '0;
          d.tx_sh = {1'b0, q.tx_sh[UART_DATA_BITS-1:1]};
          if (q.tx_bit == DATA_LAST) begin
            d.tx_line = 1'b1;
            d.tx_st = U_STOP;
          end else begin
            d.tx_bit = q.tx_bit + 1'b1;
            d.tx_line = q.tx_sh[1];
          end
        end else begin
          d.tx_cnt = q.tx_cnt + 1'b1;
        end
      end
      U_STOP: begin
        if (q.tx_cnt == BIT_LAST) begin
          d.tx_cnt = '0;
          d.tx_st = U_IDLE;
        end else begin
          d.tx_cnt = q.tx_cnt + 1'b1;
        end
      end
      default: begin
        d.tx_st = U_IDLE;
        d.tx_line = 1'b1;
      end
    endcase
  end

  // State register; pins reset to their idle-high level so no false edge appears.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.sync1 <= SYNC_IDLE;
      q.sync2 <= SYNC_IDLE;
      q.rx_st <= U_IDLE;
      q.tx_st <= U_IDLE;
      q.tx_line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Link outputs come straight from flip-flops.
  assign port_a = q.ports[PORT_A];
  assign port_b = q.ports[PORT_B];
  assign port_c = q.ports[PORT_C];
  assign port_d = q.ports[PORT_D];
  assign port_e = q.ports[PORT_E];
  assign port_f = q.ports[PORT_F];
  assign line_valid_out = q.lval;
  assign frame_valid_out = q.fval;
  assign pixel_clk_out = q.pclk;

  // Data-valid and spare bits are held high at all times.
  assign data_valid_out = 1'b1;
  assign spare_out = 1'b1;

  // Trigger and serial outputs.
  assign exposure_start = q.exp_start;
  assign ser_tfg_out = q.tx_line;
  assign rx_data = q.rx_data;
  assign rx_valid = q.rx_valid;
  assign rx_frame_err = q.rx_ferr;
  assign tx_ready = (q.tx_st == U_IDLE);
endmodule

// *** dv/tap_mapper_checker.sv ***
// Port assertions and covers for the camera tap mapper.
`timescale 1ns/1ps
module tap_mapper_checker
  import cam_tap_pkg::*;
#(
  parameter int PIX_DIV_P = 6
) (
  input logic ref_clk,
  input logic arst_n,
  input logic ten_bit_mode,
  input logic [PORT_W-1:0] port_a,
  input logic [PORT_W-1:0] port_b,
  input logic [PORT_W-1:0] port_e,
  input logic [PORT_W-1:0] port_f,
  input logic line_valid_out,
  input logic data_valid_out,
  input logic spare_out,
  input logic pixel_clk_out,
  input logic power_port_trigger_in,
  input logic link_port_trigger_in,
  input logic exposure_start,
  input logic ser_tfg_out,
  input logic rx_valid,
  input logic rx_frame_err,
  input logic tx_valid,
  input logic tx_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Link flags, strobe timing and port placement.
  a_flags_high: assert property (data_valid_out && spare_out)
    else $error("Valid or spare dropped.");
  a_strobe_period: assert property ($rose(pixel_clk_out) |-> ##6 $rose(pixel_clk_out))
    else $error("Strobe period wrong.");
  a_port_hold: assert property ($rose(pixel_clk_out) |->
    $stable({port_a, port_b, port_e, port_f, line_valid_out})) else $error("Port moved.");
  a_eight_unused: assert property (!ten_bit_mode [*8] |-> port_e == '0 && port_f == '0)
    else $error("Unused port driven.");
  a_ten_gaps: assert property (ten_bit_mode [*8] |-> port_b[3:2] == '0 &&
    port_b[7:6] == '0 && port_f[3:2] == '0) else $error("Gap bit driven.");
  // Trigger release and exposure pulse.
  a_exp_single: assert property (exposure_start |=> !exposure_start)
    else $error("Start pulse too long.");
  a_exp_release: assert property (exposure_start |->
    $past(power_port_trigger_in) && $past(link_port_trigger_in)) else $error("Start early.");
  a_exp_blocked: assert property (!power_port_trigger_in [*5] |-> !exposure_start)
    else $error("Start while held.");
  // Serial pair framing.
  a_tx_accept: assert property (tx_valid && tx_ready |=> !ser_tfg_out && !tx_ready)
    else $error("No start bit.");
  a_tx_idle_high: assert property (tx_ready |-> ser_tfg_out)
    else $error("Idle line low.");
  a_rx_pulse: assert property (rx_valid |-> !rx_frame_err ##1 !rx_valid)
    else $error("Receive pulse wrong.");

  c_exposure: cover property (exposure_start);
  c_rx_err: cover property (rx_frame_err);
  c_tx: cover property (tx_valid && tx_ready);
  c_line: cover property ($rose(line_valid_out));
endmodule

bind camera_pixel_tap_mapper tap_mapper_checker #(.PIX_DIV_P(PIX_DIV_P)) chk (
  .ref_clk, .arst_n, .ten_bit_mode, .port_a, .port_b, .port_e, .port_f,
  .line_valid_out, .data_valid_out, .spare_out, .pixel_clk_out,
  .power_port_trigger_in, .link_port_trigger_in, .exposure_start,
  .ser_tfg_out, .rx_valid, .rx_frame_err, .tx_valid, .tx_ready
);

// *** dv/grabber_model.sv ***
// Capture board model: takes link words on the strobe and speaks the serial pair.
`timescale 1ns/1ps
module grabber_model (
  input logic pixel_clk_out,
  input logic line_valid_out,
  input logic frame_valid_out,
  input logic [47:0] ports,
  input logic ser_tfg_out,
  output logic ser_tc_in,
  output logic power_port_trigger_in,
  output logic link_port_trigger_in
);
  localparam realtime BIT = 48ns;
  logic [48:0] words[$];
  logic [7:0] chars[$];

  // Unused trigger pins rest inactive high, the command line idles high.
  initial begin
    ser_tc_in = 1'b1;
    power_port_trigger_in = 1'b1;
    link_port_trigger_in = 1'b1;
  end

  // Words are taken on the rising strobe while the line flag is up.
  always @(posedge pixel_clk_out) begin
    if (line_valid_out === 1'b1) words.push_back({frame_valid_out, ports});
  end

  // Answers are decoded at mid-bit, least significant bit first.
  always @(negedge ser_tfg_out) begin
    logic [7:0] c;
    #(BIT * 1.5);
    for (int i = 0; i < 8; i++) begin
      c[i] = ser_tfg_out;
      #(BIT);
    end
    chars.push_back(c);
  end

  // Sets both trigger pins, given as {power, link}.
  task automatic trig(input logic [1:0] pl);
    {power_port_trigger_in, link_port_trigger_in} <= pl;
  endtask

  // Sends one command character with a chosen stop level.
  task automatic send(input logic [7:0] c, input logic stop);
    ser_tc_in = 1'b0;
    #(BIT);
    for (int i = 0; i < 8; i++) begin
      ser_tc_in = c[i];
      #(BIT);
    end
    ser_tc_in = stop;
    #(BIT);
    ser_tc_in = 1'b1;
    #(BIT);
  endtask
endmodule

// *** dv/camera_pixel_tap_mapper_tb_top.sv ***
// Self-checking bench for the camera tap mapper.
`timescale 1ns/1ps
module camera_pixel_tap_mapper_tb_top;
  import cam_tap_pkg::*;
  localparam int LO[4] = '{0, 2, 4, 3};
  localparam int HP[4] = '{8, 12, 40, 44};
  logic ref_clk, arst_n, pix_line, pix_frame, pix_valid, pix_ready, ten_bit_mode;
  logic [39:0] pix_taps;
  tap_count_t tap_count;
  logic [7:0] port_a, port_b, port_c, port_d, port_e, port_f, rx_data, tx_data;
  logic line_valid_out, frame_valid_out, data_valid_out, spare_out, pixel_clk_out;
  logic power_port_trigger_in, link_port_trigger_in, cc2_in, cc3_in, cc4_in;
  logic exposure_start, ser_tc_in, ser_tfg_out, rx_valid, rx_frame_err, tx_valid, tx_ready;
  logic [31:0] seed = 32'h797f_8b16;
  logic [31:0] r1, r2;
  logic [48:0] exp_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] sent[$];
  int n_errors = 0;
  int comparisons = 0;
  int n_exp = 0;
  int n_ferr = 0;
  int n0;

  camera_pixel_tap_mapper #(.UART_BIT_CYCLES_P(12), .PIX_DIV_P(6), .FIFO_DEPTH_P(8)) uut (
    .ref_clk, .arst_n, .pix_taps, .pix_line, .pix_frame, .pix_valid, .pix_ready,
    .ten_bit_mode, .tap_count, .port_a, .port_b, .port_c, .port_d, .port_e, .port_f,
    .line_valid_out, .frame_valid_out, .data_valid_out, .spare_out, .pixel_clk_out,
    .power_port_trigger_in, .link_port_trigger_in, .cc2_in, .cc3_in, .cc4_in,
    .exposure_start, .ser_tc_in, .ser_tfg_out, .rx_data, .rx_valid, .rx_frame_err,
    .tx_data, .tx_valid, .tx_ready
  );

  grabber_model grab (
    .pixel_clk_out, .line_valid_out, .frame_valid_out, .ser_tfg_out, .ser_tc_in,
    .ports({port_f, port_e, port_d, port_c, port_b, port_a}),
    .power_port_trigger_in, .link_port_trigger_in
  );

  // Free running clock at 250 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Counts start pulses, framing errors and received characters.
  always @(negedge ref_clk) begin
    if (exposure_start === 1'b1) n_exp++;
    if (rx_frame_err === 1'b1) n_ferr++;
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Expected link ports {f,e,d,c,b,a} for the current format and tap count.
  function automatic logic [47:0] map(input logic [39:0] t);
    logic [47:0] p;
    int n;
    p = '0;
    n = (tap_count == TAPS_FOUR) ? 4 : (tap_count == TAPS_TWO) ? 2 : 1;
    for (int k = 0; k < n; k++) begin
      if (!ten_bit_mode) p[8*k+:8] = t[10*k+:8];
      else begin
        p[8*LO[k]+:8] = t[10*k+:8];
        p[HP[k]+:2] = t[10*k+8+:2];
      end
    end
    return p;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("FAIL %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // Offers one word and holds it until taken; fl is {cc, line, frame}.
  task automatic push(input logic [39:0] t, input logic [2:0] fl);
    pix_taps <= t;
    {pix_line, pix_frame} <= fl[1:0];
    {cc4_in, cc3_in, cc2_in} <= {3{fl[2]}};
    pix_valid <= 1'b1;
    forever begin
      @(negedge ref_clk);
      if (pix_ready === 1'b1) break;
    end
    @(posedge ref_clk);
    if (fl[1]) exp_q.push_back({fl[0], map(t)});
  endtask

  task automatic complete_run();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #60us;
    n_errors++;
    complete_run();
  end

  initial begin
    arst_n = 1'b0;
    {pix_valid, pix_line, pix_frame, ten_bit_mode, cc2_in, cc3_in, cc4_in} = '0;
    {pix_taps, tx_data, tx_valid} = '0;
    tap_count = TAPS_ONE;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    // Every format and tap count, the undefined count too, 14 words each, waiting whenever the FIFO refuses.
    for (int m = 0; m < 8; m++) begin
      ten_bit_mode <= m[0];
      tap_count <= tap_count_t'(m / 2);
      for (int w = 0; w < 14; w++) begin
        r1 = rnd();
        r2 = rnd();
        push({r1[7:0], r2}, r1[10:8]);
      end
      pix_valid <= 1'b0;
      for (int i = 0; i < 300 && grab.words.size() < exp_q.size(); i++) @(posedge ref_clk);
      repeat (12) @(posedge ref_clk);
      check(grab.words.size(), exp_q.size(), "word count");
      while (exp_q.size() > 0 && grab.words.size() > 0)
        check(grab.words.pop_front(), exp_q.pop_front(), "pixel word");
      exp_q.delete();
      grab.words.delete();
      $display("test pixel mode %0d done", m);
    end
    // Power pin, link pin, then power pin while the link pin is held.
    for (int s = 0; s < 3; s++) begin
      n0 = n_exp;
      grab.trig(s == 0 ? 2'b01 : s == 1 ? 2'b10 : 2'b00);
      repeat (10) @(posedge ref_clk);
      grab.trig(s == 2 ? 2'b10 : 2'b11);
      repeat (12) @(posedge ref_clk);
      check(n_exp - n0, (s == 2) ? 0 : 1, "start pulses");
      grab.trig(2'b11);
      repeat (12) @(posedge ref_clk);
    end
    $display("test trigger done");
    // Two answers back to back.
    for (int i = 0; i < 2; i++) begin
      r1 = rnd();
      tx_data <= r1[7:0];
      tx_valid <= 1'b1;
      sent.push_back(r1[7:0]);
      forever begin
        @(negedge ref_clk);
        if (tx_ready === 1'b1) break;
      end
      @(posedge ref_clk);
    end
    tx_valid <= 1'b0;
    for (int i = 0; i < 400 && grab.chars.size() < 2; i++) @(posedge ref_clk);
    check(grab.chars.size(), 2, "answer count");
    while (grab.chars.size() > 0) check(grab.chars.pop_front(), sent.pop_front(), "answer");
    $display("test answer done");
    // A good command, then one with a low stop bit.
    r1 = rnd();
    #1.3ns;
    grab.send(r1[7:0], 1'b1);
    repeat (4) @(posedge ref_clk);
    check(rx_q.size(), 1, "command count");
    if (rx_q.size() > 0) check(rx_q.pop_front(), r1[7:0], "command");
    grab.send(~r1[7:0], 1'b0);
    repeat (4) @(posedge ref_clk);
    check(n_ferr, 1, "framing error");
    check(rx_q.size(), 0, "bad command kept");
    $display("test command done");
    complete_run();
  end
endmodule
